//--- pkg/eeprom_pkg.sv
// Constants, types and enumerations for the serial EEPROM slave.
// Assumes one 200 MHz system clock; all pins arrive asynchronously.
// Function
// - Slave only; all fields shift MSB first.
// - Input bits captured on rising serial clock.
// - Chip select high: ignore input, output floats.
// - Frame: 8-bit opcode, 16-bit address, data bytes.
// - Bad opcode: ignore rest, output floats.
// - Hold freezes transfer, serial clock ignored.
// - Array read/write opcodes, 15-bit address.
// - Latch set/clear opcodes, opcode only.
// - Status read/write opcodes, one status byte.
// - Latch clear at power-up; gates programming.
// - Status byte bit layout.
// - Latch bit read-only, set/cleared by commands.
// - Busy bit read-only, set while programming.
// - Guard bits need latch and programming cycle.
// - Array in four blocks, quarter/half/all protected.
// - Pin guard refuses status write when enabled.
// - Pin low during status frame rejects it.
// - Write permission combines latch, blocks, guard.
// - Latch auto-clears after programming cycle.
// - Self-timed programming, at most 5 ms.
// - Guard select address ranges table.
// - While busy only status read; returns FF.
// - Program only if select rises on byte boundary.
// - Page of 64 bytes, address wraps in page.
package eeprom_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W = 15;
    localparam int PAGE_W = 6;
    localparam int OPC_BITS = 8;
    localparam int ADDR_BITS = 16;

    // ****************************************
    // Opcodes, bit 3 masked off
    // ****************************************
    localparam logic [7:0] OPC_MASK = 8'hF7;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_SET_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
    localparam logic [7:0] OPC_STAT_READ = 8'h05;
    localparam logic [7:0] OPC_STAT_WRITE = 8'h01;

    // ****************************************
    // Status byte layout
    // ****************************************
    localparam int ST_GUARD_PIN_EN = 7;
    localparam int ST_GUARD_SEL_1 = 3;
    localparam int ST_GUARD_SEL_0 = 2;
    localparam int ST_WRITE_LATCH = 1;
    localparam int ST_BUSY = 0;
    localparam logic [7:0] STATUS_BUSY_BYTE = 8'hFF;
    localparam logic [2:0] GUARD_RESET = 3'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 200;
    localparam int PROG_TIME_MS = 5;
    localparam int PROG_CYCLES = PROG_TIME_MS * CLK_MHZ * 1000;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } pins_s;

    typedef enum logic [2:0] {
        CMD_READ, CMD_WRITE, CMD_SET_LATCH, CMD_CLR_LATCH,
        CMD_STAT_READ, CMD_STAT_WRITE, CMD_BAD
    } cmd_e;

    typedef enum logic [2:0] {
        F_IDLE, F_OPC, F_ADDR, F_DATA_IN, F_ARRAY_OUT, F_STAT_OUT, F_STAT_IN, F_DISCARD
    } frame_e;

endpackage

//--- logic/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the destination clock is the system clock.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule // pin_sync

//--- logic/prog_timer.sv
// Self-timed programming cycle counter.
// Assumes start is a one-cycle pulse, ignored while busy.
`timescale 1ns/1ps
module prog_timer #(
    parameter int CYCLES = 1000
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    logic [$clog2(CYCLES+1)-1:0] cnt_q;

    generate
        if (CYCLES < 1) begin : g_bad
            $error("prog_timer: CYCLES must be at least 1");
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (!busy_out && start_in) begin
                busy_out <= 1'b1;
                cnt_q <= $bits(cnt_q)'(CYCLES - 1);
            end else if (busy_out) begin
                if (cnt_q == '0) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule // prog_timer

//--- logic/spi_eeprom_top.sv
// Serial EEPROM slave: command decode, status byte, protection, array.
// Assumes all pins asynchronous; serial clock far slower than CLK_IN.
`timescale 1ns/1ps
module spi_eeprom_top #(
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    // System
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // Serial pins
    input wire logic CS_N_IN,
    input wire logic SCK_IN,
    input wire logic SI_IN,
    input wire logic HOLD_N_IN,
    input wire logic WP_N_IN,
    output logic SO_OUT,
    output logic SO_OE_N_OUT,
    // Status view
    output logic BUSY_OUT
);
    import eeprom_pkg::*;

    localparam int PAGE_BYTES = 1 << PAGE_W;

    generate
        if (PROG_CYCLES < 1) begin : g_bad
            $error("spi_eeprom_top: PROG_CYCLES must be at least 1");
        end
    endgenerate

    // ****************************************
    // Pin synchronisation and edges
    // ****************************************
    pins_s pins_raw;
    pins_s pins;
    logic sck_prev_q;
    logic cs_prev_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;

    assign pins_raw = '{cs_n: CS_N_IN, sck: SCK_IN, si: SI_IN,
                        hold_n: HOLD_N_IN, wp_n: WP_N_IN};

    pin_sync #(.WIDTH($bits(pins_s)), .RESET_VAL(5'h13)) u_sync (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .d_in(pins_raw),
        .q_out(pins)
    );

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= pins.sck;
            cs_prev_q <= pins.cs_n;
        end
    end

    // Edges count only in a selected, unheld frame
    assign sck_rise = pins.sck && !sck_prev_q && !pins.cs_n && pins.hold_n;
    assign sck_fall = !pins.sck && sck_prev_q && !pins.cs_n && pins.hold_n;
    assign cs_rise = pins.cs_n && !cs_prev_q;

    // ****************************************
    // State
    // ****************************************
    frame_e frame_q;
    logic [4:0] cnt_q;
    logic [7:0] shin_q;
    logic [15:0] ashift_q;
    logic is_read_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] out_q;
    logic [2:0] obit_q;
    logic [ADDR_W-PAGE_W-1:0] page_q;
    logic [PAGE_W-1:0] col_q;
    logic [PAGE_BYTES-1:0] pvalid_q;
    logic [7:0] pbuf_q [PAGE_BYTES];
    logic [7:0] mem_q [1 << ADDR_W];
    logic [7:0] stat_new_q;
    logic stat_got_q;
    logic wp_low_seen_q;
    logic [2:0] guard_q;
    logic latch_q;
    logic busy;
    logic prog_done;

    // ****************************************
    // Decode
    // ****************************************
    logic [7:0] opc;
    logic [7:0] in_byte;
    cmd_e cmd;
    logic opc_done;
    logic [7:0] status_byte;
    logic page_prot;
    logic array_commit;
    logic stat_commit;
    logic array_skip;

    assign in_byte = {shin_q[6:0], pins.si};
    assign opc = in_byte & OPC_MASK;

    always_comb begin
        case (opc)
            OPC_READ: cmd = CMD_READ;
            OPC_WRITE: cmd = CMD_WRITE;
            OPC_SET_LATCH: cmd = CMD_SET_LATCH;
            OPC_CLR_LATCH: cmd = CMD_CLR_LATCH;
            OPC_STAT_READ: cmd = CMD_STAT_READ;
            OPC_STAT_WRITE: cmd = CMD_STAT_WRITE;
            default: cmd = CMD_BAD;
        endcase
    end

    assign opc_done = sck_rise && frame_q == F_OPC && cnt_q == 5'(OPC_BITS - 1);

    // Status image; all ones while busy
    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_GUARD_PIN_EN] = guard_q[2];
        status_byte[ST_GUARD_SEL_1] = guard_q[1];
        status_byte[ST_GUARD_SEL_0] = guard_q[0];
        status_byte[ST_WRITE_LATCH] = latch_q;
        status_byte[ST_BUSY] = busy;
        if (busy) begin
            status_byte = STATUS_BUSY_BYTE;
        end
    end

    // A page never straddles a block, so its base decides
    always_comb begin
        case (guard_q[1:0])
            2'h1: page_prot = page_q[ADDR_W-PAGE_W-1 -: 2] == 2'h3;
            2'h2: page_prot = page_q[ADDR_W-PAGE_W-1];
            2'h3: page_prot = 1'b1;
            default: page_prot = 1'b0;
        endcase
    end

    // Commit only when select rises on a byte boundary
    assign array_commit = cs_rise && frame_q == F_DATA_IN && cnt_q == 5'h00
        && pvalid_q != '0 && latch_q && !page_prot && !busy;
    assign array_skip = cs_rise && frame_q == F_DATA_IN && latch_q && page_prot;
    assign stat_commit = cs_rise && frame_q == F_STAT_IN && cnt_q == 5'h00 && stat_got_q
        && latch_q && !busy && !(guard_q[2] && wp_low_seen_q);

    // ****************************************
    // Frame sequencer
    // ****************************************
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            frame_q <= F_IDLE;
            cnt_q <= 5'h00;
            shin_q <= 8'h00;
            ashift_q <= 16'h0000;
            is_read_q <= 1'b0;
            addr_q <= '0;
            page_q <= '0;
            col_q <= '0;
            pvalid_q <= '0;
            stat_new_q <= 8'h00;
            stat_got_q <= 1'b0;
        end else if (pins.cs_n) begin
            frame_q <= F_IDLE;
        end else if (frame_q == F_IDLE) begin
            frame_q <= F_OPC;
            cnt_q <= 5'h00;
            stat_got_q <= 1'b0;
            pvalid_q <= '0;
        end else if (sck_rise) begin
            shin_q <= in_byte;
            cnt_q <= cnt_q + 5'h01;
            case (frame_q)
                F_OPC: begin
                    if (cnt_q == 5'(OPC_BITS - 1)) begin
                        cnt_q <= 5'h00;
                        is_read_q <= cmd == CMD_READ;
                        if (busy && cmd != CMD_STAT_READ) begin
                            frame_q <= F_DISCARD;
                        end else begin
                            case (cmd)
                                CMD_READ, CMD_WRITE: frame_q <= F_ADDR;
                                CMD_STAT_READ: frame_q <= F_STAT_OUT;
                                CMD_STAT_WRITE: frame_q <= F_STAT_IN;
                                default: frame_q <= F_DISCARD;
                            endcase
                        end
                    end
                end
                F_ADDR: begin
                    ashift_q <= {ashift_q[14:0], pins.si};
                    if (cnt_q == 5'(ADDR_BITS - 1)) begin
                        cnt_q <= 5'h00;
                        // Top address bit is dropped
                        addr_q <= {ashift_q[13:0], pins.si};
                        page_q <= ashift_q[13:PAGE_W-1];
                        col_q <= {ashift_q[PAGE_W-2:0], pins.si};
                        frame_q <= is_read_q ? F_ARRAY_OUT : F_DATA_IN;
                    end
                end
                F_DATA_IN: begin
                    if (cnt_q == 5'h07) begin
                        cnt_q <= 5'h00;
                        pvalid_q[col_q] <= 1'b1;
                        col_q <= col_q + 1'b1;
                    end
                end
                F_STAT_IN: begin
                    if (cnt_q == 5'h07) begin
                        cnt_q <= 5'h00;
                        stat_new_q <= in_byte;
                        stat_got_q <= 1'b1;
                    end
                end
                default: cnt_q <= 5'h00;
            endcase
        end else if (sck_fall && frame_q == F_ARRAY_OUT && obit_q == 3'h0) begin
            // Address advances as each output byte is loaded
            addr_q <= addr_q + 1'b1;
        end
    end

    // ****************************************
    // Page buffer, no reset needed
    // ****************************************
    always_ff @(posedge CLK_IN) begin
        if (sck_rise && frame_q == F_DATA_IN && cnt_q == 5'h07) begin
            pbuf_q[col_q] <= in_byte;
        end
    end

    // ****************************************
    // Array, abstracted as instant write
    // ****************************************
    always_ff @(posedge CLK_IN) begin
        if (array_commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pvalid_q[i]) begin
                    mem_q[{page_q, PAGE_W'(i)}] <= pbuf_q[i];
                end
            end
        end
    end

    // ****************************************
    // Guard bits, loaded with GUARD_RESET on reset
    // ****************************************
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            guard_q <= GUARD_RESET;
        end else if (stat_commit) begin
            guard_q <= {stat_new_q[ST_GUARD_PIN_EN], stat_new_q[ST_GUARD_SEL_1],
                        stat_new_q[ST_GUARD_SEL_0]};
        end
    end

    // Any low level on the pin during the frame counts
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            wp_low_seen_q <= 1'b0;
        end else if (frame_q == F_IDLE) begin
            wp_low_seen_q <= 1'b0;
        end else if (!pins.wp_n) begin
            wp_low_seen_q <= 1'b1;
        end
    end

    // ****************************************
    // Write latch
    // ****************************************
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            latch_q <= 1'b0;
        end else if (opc_done && !busy && cmd == CMD_SET_LATCH) begin
            latch_q <= 1'b1;
        end else if (opc_done && !busy && cmd == CMD_CLR_LATCH) begin
            latch_q <= 1'b0;
        end else if (prog_done || array_skip) begin
            latch_q <= 1'b0;
        end
    end

    // ****************************************
    // Programming timer
    // ****************************************
    prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .start_in(array_commit || stat_commit),
        .busy_out(busy),
        .done_out(prog_done)
    );

    // ****************************************
    // Serial output
    // ****************************************
    // Byte loads on the falling edge that sends its top bit
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            out_q <= 8'h00;
            obit_q <= 3'h0;
            SO_OUT <= 1'b0;
            SO_OE_N_OUT <= 1'b1;
        end else if (pins.cs_n) begin
            obit_q <= 3'h0;
            SO_OE_N_OUT <= 1'b1;
        end else if (sck_fall && (frame_q == F_ARRAY_OUT || frame_q == F_STAT_OUT)) begin
            SO_OE_N_OUT <= 1'b0;
            obit_q <= obit_q + 3'h1;
            if (obit_q == 3'h0) begin
                if (frame_q == F_ARRAY_OUT) begin
                    SO_OUT <= mem_q[addr_q][7];
                    out_q <= {mem_q[addr_q][6:0], 1'b0};
                end else begin
                    SO_OUT <= status_byte[7];
                    out_q <= {status_byte[6:0], 1'b0};
                end
            end else begin
                SO_OUT <= out_q[7];
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            BUSY_OUT <= 1'b0;
        end else begin
            BUSY_OUT <= busy;
        end
    end

endmodule // spi_eeprom_top

//--- dv/spi_eeprom_chk.sv
// Checker: pin timing relations of the serial EEPROM slave.
// Assumes binding to spi_eeprom_top and a single CLK_IN domain.
`timescale 1ns/1ps
module spi_eeprom_chk #(
    parameter int PROG_CYCLES = 50
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // Serial pins
    input wire logic CS_N_IN,
    input wire logic SCK_IN,
    input wire logic SI_IN,
    input wire logic HOLD_N_IN,
    input wire logic WP_N_IN,
    input wire logic SO_OUT,
    input wire logic SO_OE_N_OUT,
    input wire logic BUSY_OUT
);
    import eeprom_pkg::*;
    // ****************************************
    // Busy length counter
    // ****************************************
    logic [31:0] busy_len_q;
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= BUSY_OUT ? busy_len_q + 32'h1 : '0;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    // Eight cycles cover the pin synchroniser delay
    chk_cs_float: assert property (CS_N_IN [*8] |-> SO_OE_N_OUT)
        else $error("Output enabled while deselected");
    chk_oe_release: assert property ($rose(CS_N_IN) |-> ##[1:6] SO_OE_N_OUT)
        else $error("Output not released after deselect");
    chk_oe_start: assert property ($fell(SO_OE_N_OUT) |-> !CS_N_IN && !SCK_IN)
        else $error("Output enabled outside low clock phase");
    chk_so_on_fall: assert property ($changed(SO_OUT) && !SO_OE_N_OUT |-> !SCK_IN)
        else $error("Output changed while serial clock high");
    chk_busy_after_cs: assert property ($rose(BUSY_OUT) |->
        CS_N_IN && $past(CS_N_IN, 2) && !SCK_IN)
        else $error("Programming started while selected");
    chk_busy_length: assert property ($fell(BUSY_OUT) |->
        busy_len_q >= PROG_CYCLES - 1 && busy_len_q <= PROG_CYCLES + 1)
        else $error("Programming cycle length wrong");
    chk_busy_bounded: assert property (busy_len_q <= PROG_CYCLES + 1)
        else $error("Programming cycle overran");
    property hold_freeze_p;
        (!HOLD_N_IN && !CS_N_IN) [*8] |-> $stable(SO_OUT) && $stable(SO_OE_N_OUT);
    endproperty
    chk_hold_freeze: assert property (hold_freeze_p)
        else $error("Output moved during hold");
    cover property ($rose(BUSY_OUT));
    cover property ($fell(SO_OE_N_OUT));
    cover property ((!HOLD_N_IN && !CS_N_IN) [*8]);
endmodule // spi_eeprom_chk
bind spi_eeprom_top spi_eeprom_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
    .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CS_N_IN(CS_N_IN), .SCK_IN(SCK_IN),
    .SI_IN(SI_IN), .HOLD_N_IN(HOLD_N_IN), .WP_N_IN(WP_N_IN), .SO_OUT(SO_OUT),
    .SO_OE_N_OUT(SO_OE_N_OUT), .BUSY_OUT(BUSY_OUT));

//--- dv/spi_host.sv
// Host serial master model for the EEPROM slave pins.
// Assumes clk_in at 200 MHz; serial clock period is 32 of its cycles.
`timescale 1ns/1ps
module spi_host (
    // Clock
    input wire logic clk_in,
    // Slave output
    input wire logic so_in,
    input wire logic so_oe_n_in,
    // Pins to slave
    output eeprom_pkg::pins_s pins_out
);
    import eeprom_pkg::*;
    initial begin
        pins_out = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end
    task automatic half();
        repeat (16) @(negedge clk_in);
    endtask
    task automatic start();
        pins_out.cs_n = 1'b0;
        half();
    endtask
    // Bits go out MSB first; returned bits are z while the slave floats
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = n - 1; i >= 0; i--) begin
            pins_out.si = tx[i];
            half();
            pins_out.sck = 1'b1;
            rx = {rx[6:0], so_oe_n_in ? 1'bz : so_in};
            half();
            pins_out.sck = 1'b0;
        end
    endtask
    task automatic stop();
        half();
        pins_out.cs_n = 1'b1;
        pins_out.si = ~pins_out.si;
        half();
        half();
    endtask
    // Clock and data keep moving while held, the slave must ignore them
    task automatic pause();
        half();
        pins_out.hold_n = 1'b0;
        repeat (4) begin
            half();
            pins_out.sck = ~pins_out.sck;
            pins_out.si = ~pins_out.si;
        end
        half();
        pins_out.hold_n = 1'b1;
    endtask
    task automatic set_guard(input logic lvl);
        pins_out.wp_n = lvl;
    endtask
endmodule // spi_host

//--- dv/testbench.sv
// Testbench: host-driven scenarios for the serial EEPROM slave.
// Assumes spi_host as serial master and the bound checker.
`timescale 1ns/1ps
module testbench;
    import eeprom_pkg::*;
    localparam int PROG = 2000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic so;
    logic so_oe_n;
    logic busy;
    pins_s pins;
    logic [7:0] rx;
    logic [7:0] q[$];
    int num_errors = 0;
    int check_count = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    spi_host host (.clk_in(clk), .so_in(so), .so_oe_n_in(so_oe_n), .pins_out(pins));
    spi_eeprom_top #(.PROG_CYCLES(PROG)) dut (
        .CLK_IN(clk), .RSTN_IN(rstn), .CS_N_IN(pins.cs_n), .SCK_IN(pins.sck),
        .SI_IN(pins.si), .HOLD_N_IN(pins.hold_n), .WP_N_IN(pins.wp_n),
        .SO_OUT(so), .SO_OE_N_OUT(so_oe_n), .BUSY_OUT(busy));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] b[$], input int extra = 0);
        q.delete();
        host.start();
        foreach (b[i]) begin
            host.shift(b[i], 8, rx);
            q.push_back(rx);
        end
        if (extra > 0) begin
            host.shift(8'h00, extra, rx);
        end
        host.stop();
    endtask
    task automatic st(input logic [7:0] exp);
        frame({OPC_STAT_READ, 8'h00});
        chk("status", q[1], exp);
    endtask
    task automatic prog(input logic [7:0] b[$], input logic exp_busy, input int extra = 0);
        frame({OPC_SET_LATCH});
        frame(b, extra);
        chk("busy", 8'(busy), 8'(exp_busy));
        if (exp_busy) begin
            frame({OPC_STAT_READ, 8'h00});
            chk("busy status", q[1], STATUS_BUSY_BYTE);
        end
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
            @(negedge clk);
        end
        chk("idle", 8'(busy), 8'h00);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_basic();
        chk("idle oe", 8'(so_oe_n), 8'h01);
        st(8'h00);
        frame({OPC_SET_LATCH | 8'h08});
        st(8'h02);
        frame({OPC_CLR_LATCH});
        st(8'h00);
    endtask
    task automatic t_page();
        prog({OPC_WRITE, 8'h00, 8'h7E, 8'hA1, 8'hB2, 8'hC3}, 1'b1);
        st(8'h00);
        frame({OPC_READ | 8'h08, 8'h00, 8'h7E, 8'h00, 8'h00});
        chk("page lo", q[3], 8'hA1);
        chk("page hi", q[4], 8'hB2);
        frame({OPC_READ, 8'h80, 8'h40, 8'h00});
        chk("page wrap", q[3], 8'hC3);
        frame({OPC_WRITE, 8'h00, 8'h7E, 8'h55});
        chk("no latch", 8'(busy), 8'h00);
        frame({OPC_READ, 8'h00, 8'h7E, 8'h00});
        chk("kept", q[3], 8'hA1);
    endtask
    task automatic t_protect();
        prog({OPC_WRITE, 8'h60, 8'h00, 8'h11}, 1'b1);
        prog({OPC_STAT_WRITE, 8'h04}, 1'b1);
        st(8'h04);
        prog({OPC_WRITE, 8'h60, 8'h00, 8'h22}, 1'b0);
        prog({OPC_WRITE, 8'h5F, 8'hC0, 8'h5A}, 1'b1);
        frame({OPC_READ, 8'h5F, 8'hC0, 8'h00});
        chk("open block", q[3], 8'h5A);
        frame({OPC_READ, 8'h60, 8'h00, 8'h00});
        chk("guarded block", q[3], 8'h11);
    endtask
    task automatic t_guard();
        prog({OPC_STAT_WRITE, 8'h84}, 1'b1);
        st(8'h84);
        host.set_guard(1'b0);
        prog({OPC_STAT_WRITE, 8'h00}, 1'b0);
        frame({OPC_STAT_READ, 8'h00});
        chk("guarded status", q[1] & 8'hFD, 8'h84);
        host.set_guard(1'b1);
        prog({OPC_STAT_WRITE, 8'h00}, 1'b1);
        st(8'h00);
    endtask
    task automatic t_abort();
        frame({8'hFF, 8'h00});
        chk("bad opcode", q[1], 8'hzz);
        prog({OPC_WRITE, 8'h00, 8'h7E, 8'h99}, 1'b0, 1);
        frame({OPC_READ, 8'h00, 8'h7E, 8'h00});
        chk("no commit", q[3], 8'hA1);
    endtask
    task automatic t_hold();
        host.start();
        host.shift(OPC_READ, 8, rx);
        host.shift(8'h00, 8, rx);
        host.shift(8'h7E, 8, rx);
        host.pause();
        host.shift(8'h00, 8, rx);
        host.stop();
        chk("held read", rx, 8'hA1);
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        t_basic();
        t_page();
        t_protect();
        t_guard();
        t_abort();
        t_hold();
        end_sim();
    end
    initial begin
        #400000;
        num_errors++;
        end_sim();
    end
endmodule // testbench
